// ### inc/eepc_params.svh
// Overview of operation
// - Input bits are taken on rising serial clock edges, modes 0 and 3.
// - Output bits change on falling serial clock edges.
// - Deselected: output floats, standby unless programming still runs.
// - Paused: output floats and input bits are ignored; select stays low.
// - First eight bits form the opcode; unknown opcodes are ignored.
// - Opcodes 03 read, 02 program, 01 status write.
// - Opcodes 06 set latch, 04 clear latch, 05 status read.
// - Ready flag reads 1 while programming, 0 when idle; not writable.
// - Set latch opcode sets write enable, clear latch opcode clears it.
// - Two guard bits persist, change only by status write, guard addresses.
// - Guard 00 none, 01 3000-3FFF, 10 2000-3FFF, 11 0000-3FFF.
// - Pin low with pin enable set blocks status writes only; array writes ignore the pin.
// - Array writes need latch set; status writes need latch and no pin block.
// - Page select set steers reads and writes to the 64-byte id page.
// - Page select is volatile, set by status write, cleared after read/write.
// - Page lock persists; once set the id page rejects every write.
// - Status write setting both page select and lock changes neither.
// - Power-up leaves the write enable latch cleared.
// - Programming starts at the select rise closing a valid write.
// - While programming, only status read is accepted.
// - Programming end clears the write enable latch.
// - Only the low 14 address bits matter for the main array.
`ifndef EEPC_PARAMS_SVH
`define EEPC_PARAMS_SVH

`define EEPC_OP_SET_WE 8'h06
`define EEPC_OP_CLR_WE 8'h04
`define EEPC_OP_STAT_RD 8'h05
`define EEPC_OP_STAT_WR 8'h01
`define EEPC_OP_READ 8'h03
`define EEPC_OP_WRITE 8'h02

`define EEPC_SB_RDY 0
`define EEPC_SB_WEL 1
`define EEPC_SB_GLO 2
`define EEPC_SB_GHI 3
`define EEPC_SB_LOCK 4
`define EEPC_SB_IDSEL 6
`define EEPC_SB_PEN 7

`define EEPC_GUARD_NONE 2'h0
`define EEPC_GUARD_QTR 2'h1
`define EEPC_GUARD_HALF 2'h2
`define EEPC_GUARD_FULL 2'h3
`define EEPC_QTR_BASE 14'h3000
`define EEPC_HALF_BASE 14'h2000

`define EEPC_ADDR_W 14
`define EEPC_ADDR_HI_W 6
`define EEPC_PAGE_W 6
`define EEPC_BIT_LAST 3'h7

`define EEPC_T_WC_MS 5
`define EEPC_REF_KHZ 10000
`define EEPC_FIFO_DEPTH 8

`endif

// ### inc/eepc_pkg.sv
package eepc_pkg;

    typedef enum logic [2:0] {
        EEPC_ST_IDLE = 3'h0,
        EEPC_ST_CMD = 3'h1,
        EEPC_ST_ADDR = 3'h3,
        EEPC_ST_DATA = 3'h2,
        EEPC_ST_SKIP = 3'h6
    } eepc_state_e;

    typedef enum logic [2:0] {
        EEPC_CMD_NONE = 3'h0,
        EEPC_CMD_SET_WE = 3'h1,
        EEPC_CMD_CLR_WE = 3'h2,
        EEPC_CMD_STAT_RD = 3'h3,
        EEPC_CMD_STAT_WR = 3'h4,
        EEPC_CMD_READ = 3'h5,
        EEPC_CMD_WRITE = 3'h6
    } eepc_cmd_e;

    typedef struct packed {
        logic [2:0] sck_s;
        logic [2:0] cs_s;
        logic [1:0] si_s;
        logic [1:0] hold_s;
        logic [1:0] wp_s;
        eepc_state_e state;
        eepc_cmd_e cmd;
        logic [2:0] bitcnt;
        logic [7:0] in_sr;
        logic addr_cnt;
        logic [5:0] addr_hi;
        logic [13:0] addr;
        logic [13:0] wr_base;
        logic [7:0] stat_new;
        logic got;
        logic overrun;
        logic [7:0] out_sr;
        logic out_en;
        logic so_q;
        logic load_pend;
        logic write_enable_latch;
        logic [1:0] guard;
        logic pin_en;
        logic id_sel;
        logic id_lock;
        logic busy;
        logic [31:0] wc;
    } eepc_core_s;

endpackage : eepc_pkg

// ### src/eepc_core.sv
`timescale 1ns/10ps
`include "eepc_params.svh"
module eepc_core
    import eepc_pkg::*;
#(
    parameter int WC_CYCLES = `EEPC_T_WC_MS * `EEPC_REF_KHZ,
    parameter int FIFO_DEPTH = `EEPC_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    output logic standby,
    output logic [`EEPC_ADDR_W-1:0] mem_rd_addr,
    output logic mem_rd_id,
    input wire logic [7:0] mem_rd_data,
    output logic prog_valid,
    input wire logic prog_ready,
    output logic prog_id,
    output logic [`EEPC_ADDR_W-1:0] prog_addr,
    output logic [7:0] prog_data
);
    localparam int PW = 1 + `EEPC_ADDR_W + 8;

    if (WC_CYCLES < 1 || FIFO_DEPTH < 2) begin : g_chk
        $error("eepc_core: WC_CYCLES must be >= 1 and FIFO_DEPTH >= 2");
    end

    eepc_core_s r;
    eepc_core_s next_r;

    logic sck_rise;
    logic sck_fall;
    logic active;
    logic cs_rise;
    logic paused;
    logic [7:0] byte_in;
    logic [`EEPC_ADDR_W-1:0] full_addr;
    logic wr_ok;
    logic st_ok;
    logic push;
    logic clr;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [PW-1:0] fifo_out;

    function automatic logic guarded(input logic [1:0] g, input logic [`EEPC_ADDR_W-1:0] a);
        case (g)
            `EEPC_GUARD_QTR: guarded = (a >= `EEPC_QTR_BASE);
            `EEPC_GUARD_HALF: guarded = (a >= `EEPC_HALF_BASE);
            `EEPC_GUARD_FULL: guarded = 1'b1;
            default: guarded = 1'b0;
        endcase
    endfunction : guarded

    // Within-page step for id page and page writes, full 14-bit wrap otherwise
    function automatic logic [`EEPC_ADDR_W-1:0] step(input logic [`EEPC_ADDR_W-1:0] a, input logic in_page);
        if (in_page) begin
            step = {a[`EEPC_ADDR_W-1:`EEPC_PAGE_W], a[`EEPC_PAGE_W-1:0] + `EEPC_PAGE_W'(1)};
        end else begin
            step = a + `EEPC_ADDR_W'(1);
        end
    endfunction : step

    function automatic logic [7:0] status_of(input eepc_core_s s);
        status_of = '0;
        status_of[`EEPC_SB_RDY] = s.busy;
        status_of[`EEPC_SB_WEL] = s.write_enable_latch;
        status_of[`EEPC_SB_GLO] = s.guard[0];
        status_of[`EEPC_SB_GHI] = s.guard[1];
        status_of[`EEPC_SB_LOCK] = s.id_lock;
        status_of[`EEPC_SB_IDSEL] = s.id_sel;
        status_of[`EEPC_SB_PEN] = s.pin_en;
    endfunction : status_of

    // Edges come from the second and third sync stages; the first stage feeds only the second
    assign sck_rise = r.sck_s[1] & ~r.sck_s[2];
    assign sck_fall = ~r.sck_s[1] & r.sck_s[2];
    assign active = ~r.cs_s[1];
    assign cs_rise = r.cs_s[1] & ~r.cs_s[2];
    assign paused = active & ~r.hold_s[1];
    assign byte_in = {r.in_sr[6:0], r.si_s[1]};
    assign full_addr = {r.addr_hi, byte_in};

    // Guarded blocks are never written; the id page also refuses when locked or fully guarded
    assign wr_ok = r.write_enable_latch && !guarded(r.guard, r.wr_base)
        && (!r.id_sel || (!r.id_lock && r.guard != `EEPC_GUARD_FULL));
    // Pin is sampled at the closing edge, so a low going pin during the frame still blocks
    assign st_ok = r.write_enable_latch && !(r.pin_en && !r.wp_s[1]);

    always_comb begin
        next_r = r;
        push = 1'b0;
        clr = 1'b0;

        next_r.sck_s = {r.sck_s[1:0], sck};
        next_r.cs_s = {r.cs_s[1:0], cs_n};
        next_r.si_s = {r.si_s[0], si};
        next_r.hold_s = {r.hold_s[0], hold_n};
        next_r.wp_s = {r.wp_s[0], wp_n};

        // Array byte is fetched one cycle after its address settles
        if (r.load_pend) begin
            next_r.out_sr = mem_rd_data;
            next_r.addr = step(r.addr, r.id_sel);
            next_r.load_pend = 1'b0;
        end

        if (r.busy) begin
            if (r.wc != 32'(WC_CYCLES - 1)) begin
                next_r.wc = r.wc + 32'h1;
            end else if (!fifo_out_valid) begin
                next_r.busy = 1'b0;
                next_r.write_enable_latch = 1'b0;
            end
        end

        if (!active) begin
            next_r.state = EEPC_ST_IDLE;
            next_r.out_en = 1'b0;
            next_r.load_pend = 1'b0;
            if (cs_rise) begin
                case (r.cmd)
                    EEPC_CMD_SET_WE: begin
                        next_r.write_enable_latch = 1'b1;
                    end
                    EEPC_CMD_CLR_WE: begin
                        next_r.write_enable_latch = 1'b0;
                    end
                    EEPC_CMD_STAT_WR: begin
                        if (r.got && st_ok) begin
                            next_r.guard = {r.stat_new[`EEPC_SB_GHI], r.stat_new[`EEPC_SB_GLO]};
                            next_r.pin_en = r.stat_new[`EEPC_SB_PEN];
                            if (!(r.stat_new[`EEPC_SB_IDSEL] && r.stat_new[`EEPC_SB_LOCK])) begin
                                next_r.id_sel = r.stat_new[`EEPC_SB_IDSEL];
                                next_r.id_lock = r.id_lock | r.stat_new[`EEPC_SB_LOCK];
                            end
                            next_r.busy = 1'b1;
                            next_r.wc = '0;
                        end
                    end
                    EEPC_CMD_WRITE: begin
                        next_r.id_sel = 1'b0;
                        if (r.got && !r.overrun && wr_ok) begin
                            next_r.busy = 1'b1;
                            next_r.wc = '0;
                        end else begin
                            clr = 1'b1;
                        end
                    end
                    EEPC_CMD_READ: begin
                        next_r.id_sel = 1'b0;
                    end
                    default: begin
                    end
                endcase
                next_r.cmd = EEPC_CMD_NONE;
            end
        end else if (r.state == EEPC_ST_IDLE) begin
            next_r.state = EEPC_ST_CMD;
            next_r.cmd = EEPC_CMD_NONE;
            next_r.bitcnt = '0;
            next_r.got = 1'b0;
            next_r.overrun = 1'b0;
            next_r.addr_cnt = 1'b0;
        end else if (sck_rise && !paused) begin
            next_r.in_sr = byte_in;
            next_r.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == `EEPC_BIT_LAST) begin
                case (r.state)
                    EEPC_ST_CMD: begin
                        next_r.state = EEPC_ST_SKIP;
                        if (r.busy && byte_in != `EEPC_OP_STAT_RD) begin
                            next_r.cmd = EEPC_CMD_NONE;
                        end else begin
                            case (byte_in)
                                `EEPC_OP_SET_WE: next_r.cmd = EEPC_CMD_SET_WE;
                                `EEPC_OP_CLR_WE: next_r.cmd = EEPC_CMD_CLR_WE;
                                `EEPC_OP_STAT_RD: begin
                                    next_r.cmd = EEPC_CMD_STAT_RD;
                                    next_r.state = EEPC_ST_DATA;
                                    next_r.out_sr = status_of(r);
                                    next_r.out_en = 1'b1;
                                end
                                `EEPC_OP_STAT_WR: begin
                                    next_r.cmd = EEPC_CMD_STAT_WR;
                                    next_r.state = EEPC_ST_DATA;
                                end
                                `EEPC_OP_READ: begin
                                    next_r.cmd = EEPC_CMD_READ;
                                    next_r.state = EEPC_ST_ADDR;
                                end
                                `EEPC_OP_WRITE: begin
                                    next_r.cmd = EEPC_CMD_WRITE;
                                    next_r.state = EEPC_ST_ADDR;
                                end
                                default: next_r.cmd = EEPC_CMD_NONE;
                            endcase
                        end
                    end
                    EEPC_ST_ADDR: begin
                        if (!r.addr_cnt) begin
                            next_r.addr_cnt = 1'b1;
                            next_r.addr_hi = byte_in[`EEPC_ADDR_HI_W-1:0];
                        end else begin
                            next_r.state = EEPC_ST_DATA;
                            next_r.addr = full_addr;
                            next_r.wr_base = full_addr;
                            if (r.cmd == EEPC_CMD_READ) begin
                                next_r.load_pend = 1'b1;
                                next_r.out_en = 1'b1;
                            end
                        end
                    end
                    EEPC_ST_DATA: begin
                        case (r.cmd)
                            EEPC_CMD_STAT_RD: next_r.out_sr = status_of(r);
                            EEPC_CMD_READ: next_r.load_pend = 1'b1;
                            EEPC_CMD_STAT_WR: begin
                                if (!r.got) begin
                                    next_r.stat_new = byte_in;
                                end
                                next_r.got = 1'b1;
                            end
                            EEPC_CMD_WRITE: begin
                                // A full buffer cannot stall the host, so the whole write is dropped
                                push = 1'b1;
                                next_r.overrun = r.overrun | ~fifo_in_ready;
                                next_r.addr = step(r.addr, 1'b1);
                                next_r.got = 1'b1;
                            end
                            default: begin
                            end
                        endcase
                    end
                    default: begin
                    end
                endcase
            end
        end

        if (active && !paused && sck_fall && r.out_en) begin
            next_r.so_q = r.out_sr[7];
            next_r.out_sr = {r.out_sr[6:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r <= '0;
            // Select and hold sync chains start at their idle high level, so no false select edge follows reset
            r.cs_s <= '1;
            r.hold_s <= '1;
        end else begin
            r <= next_r;
        end
    end

    eepc_fifo #(
        .W(PW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .clr(clr),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data({r.id_sel, r.addr, byte_in}),
        .out_valid(fifo_out_valid),
        .out_ready(prog_ready & r.busy),
        .out_data(fifo_out)
    );

    assign so = r.so_q;
    assign so_oe = active & ~paused & r.out_en;
    assign standby = ~active & ~r.busy;
    assign mem_rd_addr = r.addr;
    assign mem_rd_id = r.id_sel;
    assign prog_valid = fifo_out_valid & r.busy;
    assign prog_id = fifo_out[PW-1];
    assign prog_addr = fifo_out[PW-2:8];
    assign prog_data = fifo_out[7:0];

endmodule : eepc_core

// ### src/eepc_fifo.sv
`timescale 1ns/10ps
module eepc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || DEPTH != (1 << AW) || W < 1) begin : g_chk
        $error("eepc_fifo: DEPTH must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } eepc_fifo_s;

    eepc_fifo_s r;
    eepc_fifo_s next_r;
    logic push;
    logic pop;

    assign in_ready = (r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (r.cnt != '0);
    assign out_data = r.mem[r.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        next_r = r;
        if (clr) begin
            next_r.wp = '0;
            next_r.rp = '0;
            next_r.cnt = '0;
        end else begin
            if (push) begin
                next_r.mem[r.wp] = in_data;
                next_r.wp = r.wp + 1'b1;
            end
            if (pop) begin
                next_r.rp = r.rp + 1'b1;
            end
            if (push && !pop) begin
                next_r.cnt = r.cnt + 1'b1;
            end else if (pop && !push) begin
                next_r.cnt = r.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule : eepc_fifo

// ### test/eepc_core_assertions.sv
`timescale 1ns/10ps
module eepc_core_assertions #(
    parameter int WC_CYCLES = 20,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic hold_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic standby,
    input wire logic prog_valid,
    input wire logic prog_ready,
    input wire logic prog_id,
    input wire logic [13:0] prog_addr,
    input wire logic [7:0] prog_data
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Pins pass sync chains, so a settled level needs five samples
    sequence deselected_s;
        cs_n [*5];
    endsequence
    sequence selected_s;
        !cs_n [*5];
    endsequence
    sequence paused_s;
        !hold_n [*5];
    endsequence
    desel_float_a: assert property (deselected_s |-> !so_oe)
        else $error("serial out driven while deselected");
    sel_wake_a: assert property (selected_s |-> !standby)
        else $error("standby while selected");
    prog_awake_a: assert property (prog_valid |-> !standby)
        else $error("standby while programming");
    hold_float_a: assert property (paused_s |-> !so_oe)
        else $error("serial out driven while paused");
    fall_shift_a: assert property (so_oe && $past(so_oe) && $changed(so) |-> !$past(sck, 2))
        else $error("serial out changed without a clock fall");
    oe_cause_a: assert property ($rose(so_oe) |-> !cs_n && hold_n && $past(!cs_n) && $past(hold_n))
        else $error("serial out enabled outside an active frame");
    word_keep_a: assert property (prog_valid && !prog_ready |=> prog_valid && $stable({prog_id, prog_addr, prog_data}))
        else $error("offered word changed before taken");
    word_drop_a: assert property ($fell(prog_valid) |-> $past(prog_ready))
        else $error("offered word withdrawn");
endmodule : eepc_core_assertions
bind eepc_core eepc_core_assertions #(.WC_CYCLES(WC_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .hold_n(hold_n), .so(so), .so_oe(so_oe),
    .standby(standby), .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_id(prog_id),
    .prog_addr(prog_addr), .prog_data(prog_data));

// ### test/eepc_core_tb.sv
`timescale 1ns/10ps
module eepc_core_tb;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic wp_n = 1'h1;
    logic prog_ready = 1'h0;
    logic cs_n, sck, si, hold_n, so, so_oe, standby, mem_rd_id, prog_valid, prog_id;
    logic [13:0] mem_rd_addr, prog_addr;
    logic [7:0] mem_rd_data, prog_data, d;
    logic [22:0] words[$];
    int num_errors = 0;
    int n_compared = 0;
    always #50 ref_clk = ~ref_clk;
    // Array stand-in: main bytes echo the address, id page bytes carry bit 7
    assign mem_rd_data = mem_rd_id ? {2'h2, mem_rd_addr[5:0]} : mem_rd_addr[7:0];
    // Stalls every other cycle so offered words must wait
    always @(negedge ref_clk) prog_ready <= ~prog_ready;
    always @(posedge ref_clk) if (prog_valid && prog_ready) words.push_back({prog_id, prog_addr, prog_data});
    eepc_core #(.WC_CYCLES(600), .FIFO_DEPTH(8)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
        .so(so), .so_oe(so_oe), .standby(standby), .mem_rd_addr(mem_rd_addr), .mem_rd_id(mem_rd_id),
        .mem_rd_data(mem_rd_data), .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_id(prog_id),
        .prog_addr(prog_addr), .prog_data(prog_data));
    // A released output reads inverted, so a missing enable can never pass as data
    eepc_host_model u_host (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .so(so_oe ? so : ~so));
    task automatic chk(input string nm, input logic [22:0] seen, input logic [22:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    task automatic frame(input logic [7:0] q[$]);
        u_host.start();
        foreach (q[k]) u_host.xb(q[k], d, 8);
        u_host.stop();
    endtask : frame
    task automatic stat(output logic [7:0] s);
        frame('{8'h05, 8'h00});
        s = d;
    endtask : stat
    task automatic wait_rdy();
        logic [7:0] s;
        for (int k = 0; k < 40; k++) begin
            stat(s);
            if (s[0] === 1'h0) return;
        end
        chk("ready wait", 1'h1, 1'h0);
        give_verdict();
    endtask : wait_rdy
    task automatic t_reset();
        logic [7:0] s;
        chk("standby", standby, 1'h1);
        stat(s);
        chk("status after reset", s, 8'h00);
        chk("oe deselected", so_oe, 1'h0);
    endtask : t_reset
    task automatic t_latch();
        logic [7:0] s;
        u_host.cpol = 1'h1;
        frame('{8'h06});
        u_host.cpol = 1'h0;
        stat(s);
        chk("latch set mode 3", s, 8'h02);
        frame('{8'h04});
        stat(s);
        chk("latch cleared", s, 8'h00);
    endtask : t_latch
    task automatic t_junk();
        logic [7:0] s;
        u_host.start();
        u_host.xb(8'hFF, d, 8);
        u_host.xb(8'h06, d, 8);
        chk("oe after unknown", so_oe, 1'h0);
        u_host.stop();
        u_host.start();
        u_host.xb(8'h06, d, 7);
        u_host.stop();
        stat(s);
        chk("short opcode", s, 8'h00);
    endtask : t_junk
    task automatic t_status();
        logic [7:0] s;
        frame('{8'h06});
        frame('{8'h01, 8'h8C});
        wait_rdy();
        stat(s);
        chk("status stored", s, 8'h8C);
        wp_n = 1'h0;
        frame('{8'h06});
        frame('{8'h01, 8'h04});
        stat(s);
        chk("pin blocks store", s, 8'h8E);
        wp_n = 1'h1;
        frame('{8'h01, 8'h04});
        wait_rdy();
        stat(s);
        chk("store with pin high", s, 8'h04);
    endtask : t_status
    task automatic t_write();
        logic [7:0] s;
        frame('{8'h06});
        frame('{8'h02, 8'hF0, 8'h00, 8'hAA, 8'h55});
        stat(s);
        chk("guarded write", s, 8'h06);
        frame('{8'h02, 8'hEF, 8'hFF, 8'h5A, 8'hA5});
        stat(s);
        chk("busy status", s, 8'h07);
        chk("standby busy", standby, 1'h0);
        frame('{8'h01, 8'h00});
        wait_rdy();
        stat(s);
        chk("after program", s, 8'h04);
        chk("word count", words.size(), 2);
        chk("word 0", words[0], {1'h0, 14'h2FFF, 8'h5A});
        chk("word 1", words[1], {1'h0, 14'h2FC0, 8'hA5});
        frame('{8'h06});
        frame('{8'h01, 8'h08});
        wait_rdy();
        frame('{8'h06});
        frame('{8'h02, 8'h20, 8'h00, 8'h77});
        stat(s);
        chk("half guard write", s, 8'h0A);
    endtask : t_write
    task automatic t_read();
        u_host.start();
        u_host.xb(8'h03, d, 8);
        u_host.xb(8'h40, d, 8);
        u_host.xb(8'h05, d, 8);
        u_host.xb(8'h00, d, 8);
        chk("read byte 0", d, 8'h05);
        u_host.hold(1'h0);
        chk("oe in pause", so_oe, 1'h0);
        u_host.hold(1'h1);
        u_host.xb(8'h00, d, 8);
        chk("read byte 1", d, 8'h06);
        u_host.stop();
    endtask : t_read
    task automatic t_idpage();
        logic [7:0] s;
        frame('{8'h06});
        frame('{8'h01, 8'h50});
        wait_rdy();
        stat(s);
        chk("select with lock", s, 8'h00);
        frame('{8'h06});
        frame('{8'h01, 8'h40});
        wait_rdy();
        stat(s);
        chk("page select", s, 8'h40);
        frame('{8'h03, 8'hFF, 8'hC3, 8'h00});
        chk("id page read", d, 8'h83);
        stat(s);
        chk("select cleared", s, 8'h00);
        frame('{8'h06});
        frame('{8'h01, 8'h40});
        wait_rdy();
        frame('{8'h06});
        frame('{8'h02, 8'h00, 8'h07, 8'h3C});
        wait_rdy();
        chk("id page word", words[2], {1'h1, 14'h0007, 8'h3C});
        frame('{8'h06});
        frame('{8'h01, 8'h10});
        wait_rdy();
        frame('{8'h06});
        frame('{8'h01, 8'h40});
        wait_rdy();
        frame('{8'h06});
        frame('{8'h02, 8'h00, 8'h08, 8'h11});
        stat(s);
        chk("locked page write", s, 8'h12);
        chk("locked word count", words.size(), 3);
    endtask : t_idpage
    initial begin
        repeat (6) @(negedge ref_clk);
        rst_n = 1'h1;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_latch();
        t_junk();
        t_status();
        t_write();
        t_read();
        t_idpage();
        give_verdict();
    end
endmodule : eepc_core_tb

// ### test/eepc_host_model.sv
`timescale 1ns/10ps
module eepc_host_model (
    input wire logic ref_clk,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    input wire logic so
);
    logic cpol = 1'h0;
    initial begin
        cs_n = 1'h1;
        sck = 1'h0;
        si = 1'h0;
        hold_n = 1'h1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    // Select moves only with the clock at its idle level
    task automatic start();
        sck = cpol;
        tick(2);
        cs_n = 1'h0;
        tick(4);
    endtask : start
    task automatic stop();
        tick(4);
        sck = cpol;
        tick(4);
        cs_n = 1'h1;
        si = ~si; // Released line must not look like the last bit
        tick(8);
    endtask : stop
    // MSB first; the clock falls before each bit so both modes share one loop
    task automatic xb(input logic [7:0] o, output logic [7:0] i, input int n);
        for (int k = 7; k > 7 - n; k--) begin
            sck = 1'h0;
            si = o[k];
            tick(4);
            sck = 1'h1;
            i[k] = so;
            tick(4);
        end
    endtask : xb
    // Pause and resume only with the clock low
    task automatic hold(input logic lvl);
        sck = 1'h0;
        tick(4);
        hold_n = lvl;
        tick(6);
    endtask : hold
endmodule : eepc_host_model
